// ===== rtl/oss_pkg.sv
/*
 * shared constants, state type and helper functions of the standby and
 * oscillation settle controller.
 * assumes a single 50 MHz system clock; oscillator activity arrives as
 * synchronous one-cycle tick pulses.
 */
package oss_pkg;

    // register addresses on the special function register port
    localparam logic [15:0] OSS_ADDR_STATUS = 16'hffa3;
    localparam logic [15:0] OSS_ADDR_WAIT_SEL = 16'hffa4;

    // reset values
    localparam logic [7:0] OSS_STATUS_RST = 8'h00;
    localparam logic [7:0] OSS_WAIT_SEL_RST = 8'h05;

    // field layout
    localparam int OSS_WAIT_MSB = 2;
    localparam int OSS_STATUS_MSB = 4;

    // wait-select codes
    localparam logic [2:0] OSS_CODE_2E11 = 3'h1;
    localparam logic [2:0] OSS_CODE_2E13 = 3'h2;
    localparam logic [2:0] OSS_CODE_2E14 = 3'h3;
    localparam logic [2:0] OSS_CODE_2E15 = 3'h4;
    localparam logic [2:0] OSS_CODE_2E16 = 3'h5;

    // settle durations in high-speed oscillator cycles
    localparam logic [16:0] OSS_CYC_2E11 = 17'h0_0800;
    localparam logic [16:0] OSS_CYC_2E13 = 17'h0_2000;
    localparam logic [16:0] OSS_CYC_2E14 = 17'h0_4000;
    localparam logic [16:0] OSS_CYC_2E15 = 17'h0_8000;
    localparam logic [16:0] OSS_CYC_2E16 = 17'h1_0000;

    // cpu stall after stop release on the internal clock, in its periods
    localparam logic [4:0] OSS_IRC_STALL = 5'h11;

    // cpu clock source encodings
    localparam logic [1:0] OSS_SRC_HS = 2'h0;
    localparam logic [1:0] OSS_SRC_INT = 2'h1;
    localparam logic [1:0] OSS_SRC_SUB = 2'h2;

    // controller states, one-hot
    typedef enum logic [4:0] {
        OSS_RUN = 5'h01,
        OSS_HALT = 5'h02,
        OSS_STOP = 5'h04,
        OSS_HS_WAIT = 5'h08,
        OSS_IRC_WAIT = 5'h10
    } oss_state_t;

    // wait code to cycle count; prohibited codes fall back to the longest
    function automatic logic [16:0] oss_code_cycles(input logic [2:0] code);
        case (code)
            OSS_CODE_2E11: oss_code_cycles = OSS_CYC_2E11;
            OSS_CODE_2E13: oss_code_cycles = OSS_CYC_2E13;
            OSS_CODE_2E14: oss_code_cycles = OSS_CYC_2E14;
            OSS_CODE_2E15: oss_code_cycles = OSS_CYC_2E15;
            default: oss_code_cycles = OSS_CYC_2E16;
        endcase
    endfunction : oss_code_cycles

    // thermometer status for a count: bit 4 first, bit 0 last
    function automatic logic [4:0] oss_status_of(input logic [16:0] cnt);
        oss_status_of = {cnt >= OSS_CYC_2E11, cnt >= OSS_CYC_2E13,
                         cnt >= OSS_CYC_2E14, cnt >= OSS_CYC_2E15,
                         cnt >= OSS_CYC_2E16};
    endfunction : oss_status_of

endpackage : oss_pkg

// ===== rtl/oss_settle_counter.sv
/*
 * oscillation settle counter: counts high-speed oscillator ticks from zero
 * up to a cap and keeps a sticky thermometer status.
 * assumes hs_tick pulses only while the oscillator really oscillates.
 */
module oss_settle_counter
    import oss_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic hs_tick,
    input wire logic [16:0] cap_cycles,
    // state
    output logic [16:0] count,
    output logic [4:0] status
);

    // tick counter, stops at the cap
    always_ff @(posedge clk_sys)
    begin
        if (rst || clear)
            count <= '0;
        else if (hs_tick && count < cap_cycles)
            count <= count + 17'h0_0001;
    end

    // sticky status, filled from bit 4 down
    always_ff @(posedge clk_sys)
    begin
        if (rst || clear)
            status <= OSS_STATUS_RST[4:0];
        else
            status <= status | oss_status_of(count);
    end

endmodule : oss_settle_counter

// ===== rtl/oss_sfr_regs.sv
/*
 * special function registers: settle status (read only) and wait select.
 * assumes the cpu presents one access per strobe on the sfr port.
 */
module oss_sfr_regs
    import oss_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // sfr port
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_op,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // block side
    input wire logic [4:0] status_in,
    output logic [2:0] wait_code
);

    logic [7:0] rd_byte; // byte view of the addressed register

    // wait select, whole-byte writes only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            wait_code <= OSS_WAIT_SEL_RST[OSS_WAIT_MSB:0];
        else if (sfr_wr && !sfr_bit_op && sfr_addr == OSS_ADDR_WAIT_SEL)
            wait_code <= sfr_wdata[OSS_WAIT_MSB:0];
    end

    // read mux, unused upper bits read zero
    always_comb
    begin
        rd_byte = 8'h00;
        if (sfr_addr == OSS_ADDR_STATUS)
            rd_byte = {3'h0, status_in};
        else if (sfr_addr == OSS_ADDR_WAIT_SEL)
            rd_byte = {5'h00, wait_code};
    end

    // registered read data, held until the next read
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sfr_rdata <= 8'h00;
        else if (sfr_rd && sfr_bit_op)
            sfr_rdata <= {7'h00, rd_byte[sfr_bit_sel]};
        else if (sfr_rd)
            sfr_rdata <= rd_byte;
    end

endmodule : oss_sfr_regs

// ===== rtl/oss_standby_ctrl.sv
/*
 * standby controller: halt and stop modes, oscillator enables, cpu clock
 * gating, stop release wait and the settle status registers.
 * assumes instruction strobes are one-cycle pulses from the cpu, clock
 * select and halt bits are levels from the clock generator, and
 * oscillator ticks are synchronous one-cycle pulses.
 */

// Function
// - halt gates cpu clock, oscillators keep running
// - stop halts the high-speed oscillator
// - stop leaves on interrupt with wait; halt without
// - standby keeps registers, memory and port latches
// - internal oscillator keeps running through stop
// - internal clock cpu stalls 17 periods after stop
// - cpu resumes on its pre-standby clock source
// - reset: high-speed off, internal on, cpu internal
// - internal stop bit obeyed only if option allows
// - reset, stop or halt bits clear status
// - status fills bit 4 down to 0, sticky
// - after stop counter stops at selected wait
// - wait counted from oscillation start only
// - selected wait holds cpu only on high-speed clock
// - wait codes one to five select two-power waits
// - wait select resets 05h, byte writes only
// - status read only, bit or byte, upper zero
module oss_standby_ctrl
    import oss_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction strobes and wake request
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic irq_request,
    // clock generator state
    input wire logic [1:0] cpu_clk_sel,
    input wire logic highspeed_osc_halt_bit,
    input wire logic main_clock_halt_bit,
    input wire logic internal_osc_halt_bit,
    input wire logic peripheral_clock_source_bit,
    input wire logic opt_internal_stoppable,
    // oscillator ticks
    input wire logic hs_osc_tick,
    input wire logic internal_osc_tick,
    // sfr port
    input wire logic [15:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_bit_op,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // clock and standby controls
    output logic cpu_clk_run,
    output logic [1:0] cpu_clk_source,
    output logic hs_osc_enable,
    output logic internal_osc_enable,
    output logic periph_clk_run,
    output logic state_hold,
    output logic standby_halt,
    output logic standby_stop
);

    oss_state_t state; // current mode
    oss_state_t next_state; // mode for the next cycle
    logic stop_accept; // stop instruction taken this cycle
    logic stop_wake; // stop released this cycle
    logic hs_was_on; // high-speed oscillator ran before stop
    logic [4:0] irc_cnt; // internal periods seen since stop release
    logic [16:0] settle_cap; // counter limit
    logic [16:0] settle_cnt; // counter value
    logic [4:0] settle_status; // thermometer status
    logic [2:0] wait_code; // wait select field
    logic cnt_clear; // clear of counter and status
    logic settle_done; // selected wait has elapsed

    // stop is refused while the cpu runs on the subsystem clock
    assign stop_accept = (state == OSS_RUN) && stop_exec && !halt_exec
        && (cpu_clk_sel != OSS_SRC_SUB);
    assign stop_wake = (state == OSS_STOP) && irq_request;
    // stop or either halt bit restarts the settle measurement
    assign cnt_clear = stop_accept || highspeed_osc_halt_bit
        || main_clock_halt_bit;
    assign settle_done = settle_cnt >= settle_cap;

    // register block
    oss_sfr_regs u_regs (
        .clk_sys(clk_sys),
        .rst(rst),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_bit_op(sfr_bit_op),
        .sfr_bit_sel(sfr_bit_sel),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .status_in(settle_status),
        .wait_code(wait_code)
    );

    // settle counter, advanced only by oscillator ticks
    oss_settle_counter u_settle (
        .clk_sys(clk_sys),
        .rst(rst),
        .clear(cnt_clear),
        .hs_tick(hs_osc_tick && hs_osc_enable),
        .cap_cycles(settle_cap),
        .count(settle_cnt),
        .status(settle_status)
    );

    // mode transitions
    always_comb
    begin
        next_state = state;
        case (state)
            OSS_RUN:
            begin
                if (halt_exec)
                    next_state = OSS_HALT;
                else if (stop_accept)
                    next_state = OSS_STOP;
            end
            OSS_HALT:
            begin
                // halt wakes at once, no wait
                if (irq_request)
                    next_state = OSS_RUN;
            end
            OSS_STOP:
            begin
                if (stop_wake && cpu_clk_source == OSS_SRC_HS)
                    next_state = OSS_HS_WAIT;
                else if (stop_wake)
                    next_state = OSS_IRC_WAIT;
            end
            OSS_HS_WAIT:
            begin
                // waits for the selected count of oscillator cycles
                if (settle_done)
                    next_state = OSS_RUN;
            end
            OSS_IRC_WAIT:
            begin
                if (irc_cnt == OSS_IRC_STALL)
                    next_state = OSS_RUN;
            end
            default: next_state = OSS_RUN;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state <= OSS_RUN;
        else
            state <= next_state;
    end

    // internal-oscillator period count during the post-stop stall
    always_ff @(posedge clk_sys)
    begin
        if (rst || state != OSS_IRC_WAIT)
            irc_cnt <= 5'h00;
        else if (internal_osc_tick && irc_cnt != OSS_IRC_STALL)
            irc_cnt <= irc_cnt + 5'h01;
    end

    // counter cap: selected wait after stop, full range otherwise
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            settle_cap <= OSS_CYC_2E16;
        else if (stop_wake)
            settle_cap <= oss_code_cycles(wait_code);
        else if (highspeed_osc_halt_bit || main_clock_halt_bit)
            settle_cap <= OSS_CYC_2E16;
    end

    // remember whether the high-speed oscillator ran before stop
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            hs_was_on <= 1'b0;
        else if (stop_accept)
            hs_was_on <= hs_osc_enable;
    end

    // high-speed oscillator enable
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            hs_osc_enable <= 1'b0;
        else if (stop_accept)
            hs_osc_enable <= 1'b0;
        else if (stop_wake)
            hs_osc_enable <= hs_was_on;
        else if (state == OSS_RUN && next_state == OSS_RUN)
            hs_osc_enable <= !highspeed_osc_halt_bit;
    end

    // internal oscillator enable, kept through halt and stop
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            internal_osc_enable <= 1'b1;
        else if (state == OSS_RUN && next_state == OSS_RUN)
            internal_osc_enable <= !(internal_osc_halt_bit
                && opt_internal_stoppable);
    end

    // cpu clock source, held while in standby
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cpu_clk_source <= OSS_SRC_INT;
        else if (state == OSS_RUN && next_state == OSS_RUN)
            cpu_clk_source <= cpu_clk_sel;
    end

    // cpu clock gate, open only in run
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            cpu_clk_run <= 1'b1;
        else
            cpu_clk_run <= (next_state == OSS_RUN);
    end

    // retention hold for registers, memory and port latches
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_hold <= 1'b0;
        else
            state_hold <= (next_state != OSS_RUN);
    end

    // peripheral prescaler clock, stopped in stop and its wake phase
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            periph_clk_run <= 1'b0;
        else if (next_state == OSS_STOP || next_state == OSS_HS_WAIT
                 || next_state == OSS_IRC_WAIT)
            periph_clk_run <= 1'b0;
        else if (peripheral_clock_source_bit)
            periph_clk_run <= hs_osc_enable && settle_status[4];
        else
            periph_clk_run <= internal_osc_enable;
    end

    // mode flags for the rest of the chip
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            standby_halt <= 1'b0;
            standby_stop <= 1'b0;
        end
        else
        begin
            standby_halt <= (next_state == OSS_HALT);
            standby_stop <= (next_state == OSS_STOP);
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_stop_entry;
        (state == OSS_RUN) && stop_exec && !halt_exec
            && (cpu_clk_sel != OSS_SRC_SUB);
    endsequence

    sequence s_halt_wake;
        (state == OSS_HALT) && irq_request;
    endsequence

    a_halt_osc_kept: assert property (
        (state == OSS_HALT) |-> !cpu_clk_run && $stable(hs_osc_enable)
            && $stable(internal_osc_enable))
        else $error("halt changed oscillators or ran cpu");

    a_stop_hs_off: assert property (
        s_stop_entry |=> !hs_osc_enable && state == OSS_STOP
            && !cpu_clk_run)
        else $error("stop did not halt high-speed oscillator");

    a_halt_fast_wake: assert property (
        s_halt_wake |=> cpu_clk_run && state == OSS_RUN)
        else $error("halt release was not immediate");

    a_irc_stall_len: assert property (
        (state == OSS_IRC_WAIT && irc_cnt != OSS_IRC_STALL)
            |=> !cpu_clk_run && state_hold)
        else $error("internal clock stall not 17 periods");

    a_src_retained: assert property (
        (state != OSS_RUN) |-> $stable(cpu_clk_source))
        else $error("cpu clock source changed in standby");

    a_reset_start: assert property (
        $past(rst) |-> !hs_osc_enable && internal_osc_enable
            && cpu_clk_source == OSS_SRC_INT)
        else $error("wrong clock state after reset");

    a_intosc_locked: assert property (
        !opt_internal_stoppable && internal_osc_enable
            |=> internal_osc_enable)
        else $error("internal oscillator stopped against option");

    a_stop_clears: assert property (
        s_stop_entry |=> settle_status == 5'h00 && settle_cnt == 17'h0_0000)
        else $error("stop did not clear settle status");

    a_cap_kept: assert property (
        settle_cnt <= settle_cap)
        else $error("settle counter passed its cap");

    a_hs_wait_len: assert property (
        (state == OSS_HS_WAIT && next_state == OSS_RUN)
            |-> settle_cnt >= oss_code_cycles(wait_code) ##1 cpu_clk_run)
        else $error("cpu resumed before selected wait");

endmodule : oss_standby_ctrl

// ===== test/tb.sv
/*
 * self-checking bench of the standby and oscillation settle controller.
 * assumes oss_pkg and a 50 MHz clk_sys; ticks are driven every cycle
 * (high-speed) and every fourth cycle (internal oscillator).
 */
module tb
    import oss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and strobes
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic halt_exec = 1'h0;
    logic stop_exec = 1'h0;
    logic irq_request = 1'h0;
    // clock generator levels
    logic [1:0] cpu_clk_sel = OSS_SRC_INT;
    logic hs_halt = 1'h1;
    logic mc_halt = 1'h0;
    logic irc_halt = 1'h0;
    logic pclk_src = 1'h0;
    logic opt_stop = 1'h0;
    logic hs_osc_tick = 1'h0;
    logic internal_osc_tick = 1'h0;
    // register port
    logic [15:0] sfr_addr = 16'h0000;
    logic sfr_wr = 1'h0;
    logic sfr_rd = 1'h0;
    logic sfr_bit_op = 1'h0;
    logic [2:0] sfr_bit_sel = 3'h0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    // design outputs
    logic cpu_clk_run;
    logic [1:0] cpu_clk_source;
    logic hs_osc_enable;
    logic internal_osc_enable;
    logic periph_clk_run;
    logic state_hold;
    logic standby_halt;
    logic standby_stop;
    // bench state
    logic hs_on = 1'h0;
    logic [1:0] div = 2'h0;
    logic [7:0] d;
    logic [2:0] code;
    logic [2:0] s;
    int errors = 0;
    int n_tests = 0;
    int i;

    oss_standby_ctrl i_dut (.clk_sys(clk_sys), .rst(rst),
        .halt_exec(halt_exec), .stop_exec(stop_exec),
        .irq_request(irq_request), .cpu_clk_sel(cpu_clk_sel),
        .highspeed_osc_halt_bit(hs_halt), .main_clock_halt_bit(mc_halt),
        .internal_osc_halt_bit(irc_halt),
        .peripheral_clock_source_bit(pclk_src),
        .opt_internal_stoppable(opt_stop), .hs_osc_tick(hs_osc_tick),
        .internal_osc_tick(internal_osc_tick), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_op(sfr_bit_op),
        .sfr_bit_sel(sfr_bit_sel), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .cpu_clk_run(cpu_clk_run),
        .cpu_clk_source(cpu_clk_source), .hs_osc_enable(hs_osc_enable),
        .internal_osc_enable(internal_osc_enable),
        .periph_clk_run(periph_clk_run), .state_hold(state_hold),
        .standby_halt(standby_halt), .standby_stop(standby_stop));

    // free-running system clock
    initial
    begin
        forever #10 clk_sys = ~clk_sys;
    end

    // oscillator ticks, launched off the falling edge
    always @(negedge clk_sys)
    begin
        div <= div + 2'h1;
        hs_osc_tick <= hs_on;
        internal_osc_tick <= (div == 2'h3);
    end

    // expected thermometer status for n ticks under a count cap
    function automatic logic [7:0] exp_status(input int n, input int cap);
        int lim;
        lim = (n < cap) ? n : cap;
        exp_status = {3'h0, lim >= 2048, lim >= 8192, lim >= 16384,
                      lim >= 32768, lim >= 65536};
    endfunction : exp_status

    // settle length in ticks for a legal wait code
    function automatic int exp_cycles(input logic [2:0] c);
        exp_cycles = 1 << ((c == 3'h1) ? 11 : int'(c) + 11);
    endfunction : exp_cycles

    // byte compare
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
                            input string what);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got,
                     exp);
        end
    endtask : chk_byte

    // single flag compare
    task automatic chk_bit(input logic got, input logic exp,
                           input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit

    // wait n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // register write, one strobe then an idle cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] v,
                      input logic b);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_bit_op = b;
        sfr_wr = 1'h1;
        cyc(1);
        sfr_wr = 1'h0;
        sfr_bit_op = 1'h0;
        cyc(1);
    endtask : wr

    // register read, data taken one cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic b,
                      input logic [2:0] sel, output logic [7:0] v);
        sfr_addr = a;
        sfr_bit_op = b;
        sfr_bit_sel = sel;
        sfr_rd = 1'h1;
        cyc(1);
        sfr_rd = 1'h0;
        sfr_bit_op = 1'h0;
        v = sfr_rdata;
        cyc(1);
    endtask : rd

    // one-cycle instruction strobe, then let the state land
    task automatic strobe(input logic stop);
        stop_exec = stop;
        halt_exec = !stop;
        cyc(1);
        stop_exec = 1'h0;
        halt_exec = 1'h0;
        cyc(2);
    endtask : strobe

    // count cycles until the cpu clock runs, within lo..hi
    task automatic wait_run(input int lo, input int hi);
        int k;
        k = 0;
        while (cpu_clk_run !== 1'h1 && k < hi)
        begin
            cyc(1);
            k++;
        end
        chk_bit(k >= lo, 1'h1, "stall short");
        chk_bit(k < hi, 1'h1, "stall long");
    endtask : wait_run

    // reset pulse and the state expected just after it
    task automatic do_reset();
        rst = 1'h1;
        cyc(4);
        rst = 1'h0;
        chk_bit(cpu_clk_run, 1'h1, "run");
        chk_byte({6'h00, cpu_clk_source}, 8'h01, "src");
        chk_bit(hs_osc_enable, 1'h0, "hs en");
        chk_bit(internal_osc_enable, 1'h1, "irc en");
        chk_bit(standby_stop | standby_halt, 1'h0, "standby");
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, 8'h00, "status rst");
        rd(OSS_ADDR_WAIT_SEL, 1'h0, 3'h0, d);
        chk_byte(d, 8'h05, "wait rst");
    endtask : do_reset

    // closing verdict
    task automatic results();
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // hang guard, a little beyond the longest expected run
    initial
    begin
        repeat (98000) @(posedge clk_sys);
        errors++;
        results();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h3692));
        cyc(1);
        do_reset();
        rd(16'hffa5, 1'h0, 3'h0, d);
        chk_byte(d, 8'h00, "unmapped");
        // start the high-speed oscillator and fill the status
        hs_halt = 1'h0;
        hs_on = 1'h1;
        cyc(2100);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, exp_status(2100, 65536), "fill 11");
        rd(OSS_ADDR_STATUS, 1'h1, 3'h4, d);
        chk_byte(d, 8'h01, "bit 4");
        rd(OSS_ADDR_STATUS, 1'h1, 3'h3, d);
        chk_byte(d, 8'h00, "bit 3");
        cyc(64000);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, exp_status(66100, 65536), "fill 16");
        // status settled, so wait select may change: random codes,
        // ignored bit and status writes, bit reads
        for (i = 0; i < 6; i++)
        begin
            code = 3'($urandom_range(5, 1));
            s = 3'($urandom_range(7, 0));
            wr(OSS_ADDR_WAIT_SEL, {5'h1f, code}, 1'h0);
            wr(OSS_ADDR_WAIT_SEL, 8'h00, 1'h1);
            wr(OSS_ADDR_STATUS, 8'he0, 1'h0);
            rd(OSS_ADDR_WAIT_SEL, 1'h0, 3'h0, d);
            chk_byte(d, {5'h00, code}, "wait sel");
            rd(OSS_ADDR_WAIT_SEL, 1'h1, s, d);
            chk_byte(d, 8'(code >> s) & 8'h01, "bit");
            rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
            chk_byte(d, exp_status(66100, 65536), "status ro");
        end
        pclk_src = 1'h1;
        cyc(3);
        chk_bit(periph_clk_run, 1'h1, "periph");
        // halt bit clears status, count restarts from zero
        mc_halt = 1'h1;
        cyc(3);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, 8'h00, "cleared");
        mc_halt = 1'h0;
        cyc(2100);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, exp_status(2100, 65536), "restart");
        // halt on the high-speed clock
        cpu_clk_sel = OSS_SRC_HS;
        cyc(3);
        strobe(1'h0);
        chk_bit(cpu_clk_run, 1'h0, "halt run");
        chk_bit(hs_osc_enable, 1'h1, "hs halt");
        chk_bit(internal_osc_enable, 1'h1, "irc halt");
        chk_bit(state_hold & standby_halt, 1'h1, "hold");
        cyc($urandom_range(20, 3));
        chk_bit(cpu_clk_run, 1'h0, "still halted");
        irq_request = 1'h1;
        wait_run(0, 3);
        irq_request = 1'h0;
        chk_byte({6'h00, cpu_clk_source}, 8'h00, "halt src");
        // stop refused on the subsystem clock
        cpu_clk_sel = OSS_SRC_SUB;
        cyc(3);
        strobe(1'h1);
        chk_bit(standby_stop, 1'h0, "sub stop");
        cpu_clk_sel = OSS_SRC_HS;
        cyc(3);
        // stop on the high-speed clock with the shortest wait
        code = 3'h1;
        wr(OSS_ADDR_WAIT_SEL, {5'h00, code}, 1'h0);
        strobe(1'h1);
        chk_bit(standby_stop & state_hold, 1'h1, "stop");
        chk_bit(hs_osc_enable | periph_clk_run, 1'h0, "hs off");
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, 8'h00, "stop clr");
        hs_on = 1'h0;
        irq_request = 1'h1;
        cyc(1);
        irq_request = 1'h0;
        cyc(99);
        chk_bit(cpu_clk_run, 1'h0, "no osc");
        hs_on = 1'h1;
        wait_run(exp_cycles(code) - 4, exp_cycles(code) + 8);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, exp_status(2100, exp_cycles(code)), "cap");
        cyc(9000);
        rd(OSS_ADDR_STATUS, 1'h0, 3'h0, d);
        chk_byte(d, exp_status(11100, exp_cycles(code)), "cap");
        // stop on the internal clock, 17 internal periods of stall
        cpu_clk_sel = OSS_SRC_INT;
        cyc(3);
        strobe(1'h1);
        chk_bit(internal_osc_enable, 1'h1, "irc on");
        chk_bit(hs_osc_enable, 1'h0, "hs stop");
        cyc($urandom_range(10, 2));
        irq_request = 1'h1;
        cyc(1);
        irq_request = 1'h0;
        wait_run(58, 76);
        chk_byte({6'h00, cpu_clk_source}, 8'h01, "irc src");
        // internal oscillator stop bit obeyed only with the option
        cpu_clk_sel = OSS_SRC_HS;
        irc_halt = 1'h1;
        cyc(4);
        chk_bit(internal_osc_enable, 1'h1, "irc kept");
        opt_stop = 1'h1;
        cyc(4);
        chk_bit(internal_osc_enable, 1'h0, "irc off");
        // second reset in mid-run
        irc_halt = 1'h0;
        hs_halt = 1'h1;
        cpu_clk_sel = OSS_SRC_INT;
        do_reset();
        results();
    end

endmodule : tb
